// >>> rtl/tpw_pkg.sv
// Package: register map, field positions and reset values of the timer PWM block
package tpw_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [11:0] MODE_OFS   = 12'h000;
  localparam logic [11:0] COUNT_OFS  = 12'h004;
  localparam logic [11:0] REF_OFS    = 12'h008;
  localparam logic [11:0] STAT_OFS   = 12'h00C;
  localparam logic [11:0] MASK_OFS   = 12'h010;
  // ==========================================================
  // Mode register fields and register reset values
  localparam int ENB_BIT   = 7;
  localparam int RATE_LSB  = 4;
  localparam int RSH_BIT   = 3;
  localparam int RSL_BIT   = 2;
  localparam int PWMOE_BIT = 1;
  localparam int IEN_BIT   = 0;
  localparam logic [7:0] MODE_RST  = 8'h00;
  localparam logic [7:0] REF_RST   = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;

  typedef struct packed {
    logic       enable;
    logic [2:0] rate;
    logic       range_hi;
    logic       range_lo;
    logic       pwm_oe;
    logic       irq_en;
  } tpw_mode_t;
endpackage

// >>> rtl/tpw_top.sv
// Timer based PWM generator with APB register access
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/100ps
module tpw_top #(
  parameter int RATE_W = 3
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        gpio_out,
  input  wire logic        gpio_oe,
  output logic             pin_out,
  output logic             pin_oe,
  output logic             irq
);
  // ==========================================================
  // Registers
  tpw_pkg::tpw_mode_t mode_q;
  logic [7:0]         count_q;
  logic [7:0]         ref_buf_q;
  logic [7:0]         ref_act_q;
  logic [6:0]         div_q;
  logic               pwm_q;
  logic               stat_q;
  logic               mask_q;
  logic               wr_en;
  logic               rd_en;
  logic               tick;
  logic               wrap;
  logic [7:0]         vmask;
  logic               stat_clr;
  logic [7:0]         cnt_nx;
  logic [7:0]         cnt_inc;
  logic [7:0]         wdata_lo;
  logic               cnt_wr;
  logic               mode_wr;
  logic               ref_wr;

  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign cnt_wr   = wr_en && paddr == tpw_pkg::COUNT_OFS;
  assign mode_wr  = wr_en && paddr == tpw_pkg::MODE_OFS;
  assign ref_wr   = wr_en && paddr == tpw_pkg::REF_OFS;
  assign wdata_lo = pwdata[7:0];
  assign cnt_inc  = (count_q + 8'h01) & vmask;

  function automatic logic [7:0] range_mask(input logic hi, input logic lo);
    case ({hi, lo})
      2'b00:   range_mask = 8'hFF;
      2'b01:   range_mask = 8'h3F;
      2'b10:   range_mask = 8'h1F;
      default: range_mask = 8'h0F;
    endcase
  endfunction

  assign vmask = range_mask(mode_q.range_hi, mode_q.range_lo);

  // ==========================================================
  // Rate prescaler: rate n ticks every 2^(7-n) clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 7'h00;
    end else if (!mode_q.enable) begin
      div_q <= 7'h00;
    end else begin
      div_q <= div_q + 7'h01;
    end
  end

  always_comb begin
    logic [6:0] sel;
    sel  = 7'h7F >> mode_q.rate;
    tick = mode_q.enable && ((div_q & sel) == sel);
  end

  assign wrap = tick && ((count_q & vmask) == vmask);

  // Compare on the next count so the output lines up with the counter
  always_comb begin
    if (cnt_wr) begin
      cnt_nx = wdata_lo & vmask;
    end else if (wrap) begin
      cnt_nx = 8'h00;
    end else if (tick) begin
      cnt_nx = cnt_inc;
    end else begin
      cnt_nx = count_q & vmask;
    end
  end

  // ==========================================================
  // Counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= tpw_pkg::COUNT_RST;
    end else if (cnt_wr) begin
      count_q <= wdata_lo;
    end else if (wrap) begin
      count_q <= 8'h00;
    end else if (tick) begin
      count_q <= cnt_inc;
    end
  end

  // ==========================================================
  // Duty reference, double buffered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_buf_q <= tpw_pkg::REF_RST;
    end else if (wr_en && paddr == tpw_pkg::REF_OFS) begin
      ref_buf_q <= pwdata[7:0];
    end
  end

  // Loading only at wrap or while disabled keeps a period free of double edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_act_q <= tpw_pkg::REF_RST;
    end else if (wrap || !mode_q.enable) begin
      ref_act_q <= ref_buf_q;
    end
  end

  // ==========================================================
  // PWM output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_q <= 1'b0;
    end else if (!mode_q.enable) begin
      pwm_q <= 1'b0;
    end else if (wrap) begin
      pwm_q <= ((ref_buf_q & vmask) != 8'h00);
    end else begin
      pwm_q <= (cnt_nx < (ref_act_q & vmask));
    end
  end

  assign pin_out = mode_q.pwm_oe ? pwm_q : gpio_out;
  assign pin_oe  = mode_q.pwm_oe ? 1'b1 : gpio_oe;

  // ==========================================================
  // Mode and mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= tpw_pkg::MODE_RST;
    end else if (wr_en && paddr == tpw_pkg::MODE_OFS) begin
      mode_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= 1'b0;
    end else if (wr_en && paddr == tpw_pkg::MASK_OFS) begin
      mask_q <= pwdata[0];
    end
  end

  // ==========================================================
  // Interrupt flag: set wins over write-one-to-clear
  assign stat_clr = wr_en && paddr == tpw_pkg::STAT_OFS && pwdata[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= 1'b0;
    end else if (wrap) begin
      stat_q <= 1'b1;
    end else if (stat_clr) begin
      stat_q <= 1'b0;
    end
  end

  assign irq = stat_q && mask_q && mode_q.irq_en;

  // ==========================================================
  // Read path; reference reads as zero since software must not read it back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        if (paddr == tpw_pkg::MODE_OFS) begin
          prdata <= {24'h000000, mode_q};
        end else if (paddr == tpw_pkg::COUNT_OFS) begin
          prdata <= {24'h000000, count_q};
        end else if (paddr == tpw_pkg::REF_OFS) begin
          prdata <= 32'h0000_0000;
        end else if (paddr == tpw_pkg::STAT_OFS) begin
          prdata <= {31'h0, stat_q};
        end else if (paddr == tpw_pkg::MASK_OFS) begin
          prdata <= {31'h0, mask_q};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Assertions
  a_wrap_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    wrap |=> stat_q) else $error("Overflow did not set flag");
  a_wrap_zero_count: assert property (@(posedge pclk) disable iff (!presetn)
    wrap && !(wr_en && paddr == tpw_pkg::COUNT_OFS) |=> count_q == 8'h00)
    else $error("Counter did not wrap to zero");
  a_ref_load_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q.enable && !wrap |=> $stable(ref_act_q)) else $error("Reference changed mid period");
  a_disable_stops: assert property (@(posedge pclk) disable iff (!presetn)
    !mode_q.enable |=> !pwm_q && div_q == 7'h00) else $error("Disabled timer still active");
  a_zero_ref_low: assert property (@(posedge pclk) disable iff (!presetn)
    ref_act_q == 8'h00 && ref_buf_q == 8'h00 |=> !pwm_q) else $error("Zero duty went high");
  a_wrap_high: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q.enable && wrap && (ref_buf_q & vmask) != 8'h00 ##1 mode_q.enable |-> pwm_q)
    else $error("Wrap did not raise output");
  a_pin_takeover: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q.pwm_oe |-> pin_oe && pin_out == pwm_q) else $error("Pin not taken over");
  a_count_range: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q.enable && !$past(wr_en) |-> (count_q & ~vmask) == 8'h00 || $changed(vmask))
    else $error("Counter beyond modulus");
  a_compare_low: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q.enable && !wrap && (count_q & vmask) >= (ref_act_q & vmask) ##1 mode_q.enable
    |-> !pwm_q) else $error("Output high at or past reference");

  // ==========================================================
  // Compare and period checks
  a_pwm_compare: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q.enable && !mode_wr && !cnt_wr
    |=> pwm_q == ((count_q & vmask) < (ref_act_q & vmask)))
    else $error("Output does not follow compare");

  a_zero_ref_hold: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q.enable && (ref_act_q & vmask) == 8'h00 && !wrap && !mode_wr
    |=> !pwm_q)
    else $error("Zero duty output high");

  a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    tick && !wrap && !cnt_wr
    |=> count_q == $past(cnt_inc))
    else $error("Counter did not advance");

  a_count_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !tick && !cnt_wr
    |=> $stable(count_q))
    else $error("Counter moved without tick");

  a_wrap_tick: assert property (@(posedge pclk) disable iff (!presetn)
    wrap
    |-> tick && mode_q.enable)
    else $error("Wrap without tick");

  a_wrap_at_mask: assert property (@(posedge pclk) disable iff (!presetn)
    tick && (count_q & vmask) == vmask
    |-> wrap)
    else $error("Missed wrap at modulus");

  a_rate_full: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q.enable && mode_q.rate == 3'h7
    |-> tick)
    else $error("Fastest rate missed a tick");

  a_rate_half: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q.enable && mode_q.rate == 3'h6 && tick && !mode_wr
    |=> !tick)
    else $error("Half rate ticked twice");

  a_range_256: assert property (@(posedge pclk) disable iff (!presetn)
    !mode_q.range_hi && !mode_q.range_lo
    |-> vmask == 8'hFF)
    else $error("Range 256 mask wrong");

  a_range_64: assert property (@(posedge pclk) disable iff (!presetn)
    !mode_q.range_hi && mode_q.range_lo
    |-> vmask == 8'h3F)
    else $error("Range 64 mask wrong");

  a_range_32: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q.range_hi && !mode_q.range_lo
    |-> vmask == 8'h1F)
    else $error("Range 32 mask wrong");

  a_range_16: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q.range_hi && mode_q.range_lo
    |-> vmask == 8'h0F)
    else $error("Range 16 mask wrong");

  // ==========================================================
  // Reference buffer and mode write checks
  a_buf_write: assert property (@(posedge pclk) disable iff (!presetn)
    ref_wr
    |=> ref_buf_q == $past(wdata_lo))
    else $error("Reference buffer not written");

  a_buf_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !ref_wr
    |=> $stable(ref_buf_q))
    else $error("Reference buffer changed");

  a_act_load: assert property (@(posedge pclk) disable iff (!presetn)
    wrap
    |=> ref_act_q == $past(ref_buf_q))
    else $error("Active reference not loaded");

  a_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
    mode_wr
    |=> mode_q == $past(wdata_lo))
    else $error("Mode word not written");

  // ==========================================================
  // Flag, interrupt, pin and read checks
  a_stat_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    stat_q && !stat_clr
    |=> stat_q)
    else $error("Flag dropped without clear");

  a_stat_clear: assert property (@(posedge pclk) disable iff (!presetn)
    stat_clr && !wrap
    |=> !stat_q)
    else $error("Flag not cleared");

  a_stat_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !stat_q && !wrap
    |=> !stat_q)
    else $error("Flag set without overflow");

  a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
    !mask_q || !mode_q.irq_en
    |-> !irq)
    else $error("Masked interrupt raised");

  a_irq_raised: assert property (@(posedge pclk) disable iff (!presetn)
    stat_q && mask_q && mode_q.irq_en
    |-> irq)
    else $error("Interrupt not raised");

  a_pin_gpio: assert property (@(posedge pclk) disable iff (!presetn)
    !mode_q.pwm_oe
    |-> pin_oe == gpio_oe && pin_out == gpio_out)
    else $error("Pin not released to port");

  a_ref_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && paddr == tpw_pkg::REF_OFS
    |=> prdata == 32'h0000_0000)
    else $error("Reference read back");
endmodule // tpw_top

// >>> bench/tpw_load.sv
// Load on the shared pin: pull-down, measures PWM period and high time
`timescale 1ns/100ps
module tpw_load (
  input  wire logic       pclk,
  input  wire logic       pin_out,
  input  wire logic       pin_oe,
  output logic      [8:0] per,
  output logic      [8:0] hi
);
  logic       lvl_q;
  logic [8:0] cnt_q;
  logic [8:0] hcnt_q;
  // Pull-down sets the level whenever the pin is left undriven
  wire        lvl = pin_oe ? pin_out : 1'b0;
  initial begin
    lvl_q  = 1'b0;
    cnt_q  = 9'h000;
    hcnt_q = 9'h000;
    per    = 9'h000;
    hi     = 9'h000;
  end
  // ==========================================================
  // Rise to rise is one period
  always @(posedge pclk) begin
    lvl_q <= lvl;
    if (lvl && !lvl_q) begin
      per    <= cnt_q;
      hi     <= hcnt_q;
      cnt_q  <= 9'h001;
      hcnt_q <= 9'h001;
    end else begin
      cnt_q  <= cnt_q + 9'h001;
      hcnt_q <= hcnt_q + {8'h00, lvl};
    end
  end
endmodule // tpw_load

// >>> bench/tb.sv
// Self-checking testbench of the timer PWM block
`timescale 1ns/100ps
module tb;
  logic        pclk, presetn, psel, penable, pwrite, gpio_out, gpio_oe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        pready, pslverr, pin_out, pin_oe, irq, e;
  logic [8:0]  per, hi;
  int          mismatches, tests_run, k;
  tpw_top tpw_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pin_out(pin_out),
    .pin_oe(pin_oe), .irq(irq));
  tpw_load tpw_load_inst (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .per(per), .hi(hi));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // ==========================================================
  // Checks and bus cycles
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    tests_run++;
    if (g !== x) begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, m, g, x);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Run mode word: enable, rate, range, output enable, irq enable
  function automatic logic [31:0] md(input logic [1:0] g, input logic [2:0] t, input logic i);
    return {24'h000000, 1'b1, t, g, 1'b1, i};
  endfunction
  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    for (k = 0; k < 5; k++) begin
      xfer(1'b0, 12'(k * 4), 32'h0);
      chk(r, 32'h0, "reset value");
    end
    xfer(1'b1, 12'h008, 32'h000000A5);
    xfer(1'b0, 12'h008, 32'h0);
    chk(r, 32'h0, "reference reads zero");
    xfer(1'b0, 12'h014, 32'h0);
    chk({31'h0, e}, 32'h1, "unmapped error");
    gpio_oe <= 1'b1;
    gpio_out <= 1'b1;
    cyc(2);
    chk({30'h0, pin_oe, pin_out}, 32'h3, "gpio owns pin");
  endtask
  task automatic t_duty(input logic [1:0] g, input logic [2:0] t, input logic [8:0] m);
    xfer(1'b1, 12'h008, 32'h35);
    xfer(1'b1, 12'h000, md(g, t, 1'b0) & 32'h0000007F);
    xfer(1'b1, 12'h000, md(g, t, 1'b0));
    cyc(8 * m);
    chk({23'h0, per}, 32'(m * (1 << (7 - t))), "period");
    chk({23'h0, hi}, 32'((8'h35 & (m - 1)) * (1 << (7 - t))), "high time");
    chk({31'h0, pin_oe}, 32'h1, "pwm owns pin");
  endtask
  task automatic t_zero();
    xfer(1'b1, 12'h008, 32'h0);
    cyc(40);
    e = 1'b0;
    for (k = 0; k < 64; k++) begin
      e = e | (pin_out !== 1'b0);
      @(posedge pclk);
    end
    chk({31'h0, e}, 32'h0, "zero duty low");
  endtask
  task automatic t_dbuf();
    xfer(1'b1, 12'h008, 32'h5);
    cyc(40);
    @(posedge pin_out);
    @(posedge pclk);
    xfer(1'b1, 12'h008, 32'hC);
    @(posedge pin_out);
    cyc(2);
    chk({23'h0, hi}, 32'(5 << 1), "old duty kept");
    @(posedge pin_out);
    cyc(2);
    chk({23'h0, hi}, 32'(12 << 1), "new duty");
  endtask
  task automatic t_irq();
    logic [31:0] c0;
    xfer(1'b1, 12'h010, 32'h0);
    xfer(1'b1, 12'h000, md(2'b11, 3'h7, 1'b1));
    cyc(40);
    chk({31'h0, irq}, 32'h0, "masked irq");
    xfer(1'b1, 12'h010, 32'h1);
    chk({31'h0, irq}, 32'h1, "irq raised");
    xfer(1'b1, 12'h000, 32'h00000073);
    xfer(1'b0, 12'h004, 32'h0);
    c0 = r;
    cyc(40);
    xfer(1'b0, 12'h004, 32'h0);
    chk(r, c0, "counter stopped");
    xfer(1'b1, 12'h00C, 32'h1);
    xfer(1'b0, 12'h00C, 32'h0);
    chk(r, 32'h0, "status cleared");
    chk({31'h0, irq}, 32'h0, "irq cleared");
  endtask
  initial begin
    mismatches = 0;
    tests_run = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, gpio_out, gpio_oe} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    cyc(10);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_duty(2'b00, 3'h7, 9'd256);
    t_duty(2'b01, 3'h7, 9'd64);
    t_duty(2'b10, 3'h7, 9'd32);
    t_duty(2'b11, 3'h7, 9'd16);
    t_duty(2'b11, 3'h6, 9'd16);
    t_zero();
    t_dbuf();
    t_irq();
    conclude();
  end
  initial begin
    #(8 * 30000);
    mismatches++;
    conclude();
  end
endmodule // tb
